// [coc_consts.vh]
// Constants for the complementary output count core.
`ifndef COC_CONSTS_VH
`define COC_CONSTS_VH
`define COC_OFF_CTRL      8'h00
`define COC_OFF_OUTCFG    8'h04
`define COC_OFF_EVENT     8'h08
`define COC_OFF_CNT       8'h24
`define COC_OFF_DIV       8'h28
`define COC_OFF_RELOAD    8'h2C
`define COC_ADDR_W        8
`define COC_CNT_RST       16'h0000
`define COC_DIV_RST       16'h0000
`define COC_RELOAD_RST    16'hFFFF
`define COC_ZERO16        16'h0000
`define COC_ONE16         16'h0001
`define COC_CTRL_MAIN_EN  0
`define COC_CTRL_IDLE_SEL 1
`define COC_CTRL_RUN_SEL  2
`define COC_CTRL_CEN      3
`define COC_CTRL_SLVRST   4
`define COC_CTRL_DT_LSB   8
`define COC_CTRL_DT_MSB   15
`define COC_CTRL_MASK     32'h0000FF1F
`define COC_OC_CH_EN      0
`define COC_OC_CMP_EN     1
`define COC_OC_CH_POL     2
`define COC_OC_CMP_POL    3
`define COC_OC_CH_IDLE    4
`define COC_OC_CMP_IDLE   5
`define COC_OC_MASK       32'h0000003F
`define COC_EV_UPDATE     0
`define COC_RESP_OKAY     2'h0
`define COC_RESP_SLVERR   2'h2
`endif

// [coc_count_core.v]
// Counter, prescaler and complementary output gating with an AXI4-Lite slave.
// How it works
// - Run, run select clear, no enables: both outputs zero, undriven.
// - Channel only: channel follows reference XOR polarity.
// - Both enabled: complementary pair with dead-time.
// - Run select set, none enabled: polarity levels, undriven.
// - Complementary only: channel held at polarity, driven.
// - Channel only: complementary held at polarity, driven.
// - Idle, idle select clear: both outputs disconnected.
// - Idle select set, either enabled: drive both at polarity.
// - After dead-time, drive idle levels unless both active.
// - Counter tick is input clock over divider+1.
// - New divider takes effect on update only.
// - Update-generate or slave reset clears prescaler.
// - Reload register resets to all ones.
// - Counter halts while reload value is zero.
// - Break input clears main output enable asynchronously.
`timescale 1ns/1ns
`default_nettype none
`include "coc_consts.vh"
module coc_count_core (
	input  wire        clk,
	input  wire        reset,
	input  wire        breakIn,
	input  wire        referenceWaveform,
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output reg         awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output reg         wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output reg         arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	output reg         channelOutput,
	output reg         channelDriveEnable,
	output reg         complementaryOutput,
	output reg         complementaryDriveEnable,
	output reg         updateEvent
);
	reg  [31:0] ctrl_q;
	reg  [31:0] outCfg_q;
	reg  [15:0] countField_q;
	reg  [15:0] dividerField_q;
	reg  [15:0] activeDivider_q;
	reg  [15:0] reloadField_q;
	reg  [15:0] prescaleCnt_q;
	reg  [7:0]  deadCnt_q;
	reg         refDelay_q;
	reg         idleSettled_q;
	reg         idleLoaded_q;
	reg         mainOutputEnable_q;
	reg  [7:0]  awAddr_q;
	reg  [31:0] wData_q;
	reg  [3:0]  wStrb_q;
	reg         awHeld_q;
	reg         wHeld_q;
	reg  [7:0]  writeAddr;
	reg  [31:0] writeData;
	reg  [3:0]  writeStrb;
	reg         doWrite;
	reg         writeMapped;
	reg         mainOutputSet;
	reg         mainOutputClr;
	wire        updateGenerate;
	wire        slaveReset;
	wire        counterTick;
	wire        wrapNow;
	wire [7:0]  deadTime;
	wire        runOffSel;
	wire        idleOffSel;
	wire        chEn;
	wire        cmpEn;
	wire        chPol;
	wire        cmpPol;
	wire        chIdle;
	wire        cmpIdle;
	wire        idleOffActive;
	wire        deadHold;
	reg         chOutD;
	reg         chEnD;
	reg         cmpOutD;
	reg         cmpEnD;

	// Merges a byte-enabled write into a 32-bit word.
	function [31:0] mergeBytes;
		input [31:0] oldWord;
		input [31:0] newWord;
		input [3:0]  strb;
		integer i;
		begin
			mergeBytes = oldWord;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					mergeBytes[i*8 +: 8] = newWord[i*8 +: 8];
			end
		end
	endfunction

	function [15:0] mergeLow;
		input [15:0] oldHalf;
		input [31:0] newWord;
		input [1:0]  strb;
		begin
			mergeLow[7:0] = strb[0] ? newWord[7:0] : oldHalf[7:0];
			mergeLow[15:8] = strb[1] ? newWord[15:8] : oldHalf[15:8];
		end
	endfunction

	function isMapped;
		input [7:0] addr;
		begin
			isMapped = (addr == `COC_OFF_CTRL) || (addr == `COC_OFF_OUTCFG) ||
				(addr == `COC_OFF_EVENT) || (addr == `COC_OFF_CNT) ||
				(addr == `COC_OFF_DIV) || (addr == `COC_OFF_RELOAD);
		end
	endfunction

	// Write channel: address and data may arrive in either order.
	always @* begin
		writeAddr = awHeld_q ? awAddr_q : awaddr;
		writeData = wHeld_q ? wData_q : wdata;
		writeStrb = wHeld_q ? wStrb_q : wstrb;
		doWrite = (awHeld_q || (awvalid && awready)) && (wHeld_q || (wvalid && wready)) &&
			!bvalid;
		writeMapped = isMapped(writeAddr);
	end

	assign updateGenerate = doWrite && (writeAddr == `COC_OFF_EVENT) && writeStrb[0] &&
		writeData[`COC_EV_UPDATE];
	assign slaveReset = ctrl_q[`COC_CTRL_SLVRST];

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			awready <= 1'b0;
			wready <= 1'b0;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `COC_RESP_OKAY;
		end else begin
			awready <= !awHeld_q && !(awvalid && awready) && !bvalid;
			wready <= !wHeld_q && !(wvalid && wready) && !bvalid;
			if (awvalid && awready && !doWrite) begin
				awHeld_q <= 1'b1;
				awAddr_q <= awaddr;
			end
			if (wvalid && wready && !doWrite) begin
				wHeld_q <= 1'b1;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (doWrite) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				awready <= 1'b0;
				wready <= 1'b0;
				bvalid <= 1'b1;
				bresp <= writeMapped ? `COC_RESP_OKAY : `COC_RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Configuration registers; the counter registers are handled with the count logic.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= 32'h00000000;
			outCfg_q <= 32'h00000000;
			dividerField_q <= `COC_DIV_RST;
			reloadField_q <= `COC_RELOAD_RST;
		end else if (doWrite) begin
			case (writeAddr)
				`COC_OFF_CTRL:   ctrl_q <= mergeBytes(ctrl_q, writeData, writeStrb) &
					`COC_CTRL_MASK;
				`COC_OFF_OUTCFG: outCfg_q <= mergeBytes(outCfg_q, writeData, writeStrb) &
					`COC_OC_MASK;
				`COC_OFF_DIV:    dividerField_q <= mergeLow(dividerField_q, writeData, writeStrb[1:0]);
				`COC_OFF_RELOAD: reloadField_q <= mergeLow(reloadField_q, writeData, writeStrb[1:0]);
				default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	// Main output enable: software sets or clears it, break forces it low at once.
	always @* begin
		mainOutputSet = doWrite && (writeAddr == `COC_OFF_CTRL) && writeStrb[0] &&
			writeData[`COC_CTRL_MAIN_EN];
		mainOutputClr = doWrite && (writeAddr == `COC_OFF_CTRL) && writeStrb[0] &&
			!writeData[`COC_CTRL_MAIN_EN];
	end

	always @(posedge clk or posedge reset or posedge breakIn) begin
		if (reset)
			mainOutputEnable_q <= 1'b0;
		else if (breakIn)
			mainOutputEnable_q <= 1'b0;
		else if (mainOutputSet)
			mainOutputEnable_q <= 1'b1;
		else if (mainOutputClr)
			mainOutputEnable_q <= 1'b0;
	end

	// Prescaler divides the input clock by the active divider plus one.
	assign counterTick = (prescaleCnt_q == activeDivider_q) &&
		(reloadField_q != `COC_ZERO16) && ctrl_q[`COC_CTRL_CEN];
	assign wrapNow = counterTick && (countField_q >= reloadField_q);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			prescaleCnt_q <= `COC_ZERO16;
			activeDivider_q <= `COC_DIV_RST;
			countField_q <= `COC_CNT_RST;
			updateEvent <= 1'b0;
		end else begin
			updateEvent <= wrapNow || updateGenerate;
			if (updateGenerate || slaveReset) begin
				prescaleCnt_q <= `COC_ZERO16;
			end else if (reloadField_q == `COC_ZERO16 || !ctrl_q[`COC_CTRL_CEN]) begin
				prescaleCnt_q <= prescaleCnt_q;
			end else if (prescaleCnt_q >= activeDivider_q) begin
				prescaleCnt_q <= `COC_ZERO16;
			end else begin
				prescaleCnt_q <= prescaleCnt_q + `COC_ONE16;
			end
			if (wrapNow || updateGenerate)
				activeDivider_q <= dividerField_q;
			if (doWrite && writeAddr == `COC_OFF_CNT)
				countField_q <= mergeLow(countField_q, writeData, writeStrb[1:0]);
			else if (updateGenerate || wrapNow)
				countField_q <= `COC_ZERO16;
			else if (counterTick)
				countField_q <= countField_q + `COC_ONE16;
		end
	end

	// Read channel answers one cycle after the address is taken.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `COC_RESP_OKAY;
		end else begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rresp <= isMapped(araddr) ? `COC_RESP_OKAY : `COC_RESP_SLVERR;
				case (araddr)
					`COC_OFF_CTRL:   rdata <= {ctrl_q[31:1], mainOutputEnable_q};
					`COC_OFF_OUTCFG: rdata <= outCfg_q;
					`COC_OFF_CNT:    rdata <= {16'h0000, countField_q};
					`COC_OFF_DIV:    rdata <= {16'h0000, dividerField_q};
					`COC_OFF_RELOAD: rdata <= {16'h0000, reloadField_q};
					default:         rdata <= 32'h00000000;
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	assign deadTime   = ctrl_q[`COC_CTRL_DT_MSB:`COC_CTRL_DT_LSB];
	assign runOffSel  = ctrl_q[`COC_CTRL_RUN_SEL];
	assign idleOffSel = ctrl_q[`COC_CTRL_IDLE_SEL];
	assign chEn    = outCfg_q[`COC_OC_CH_EN];
	assign cmpEn   = outCfg_q[`COC_OC_CMP_EN];
	assign chPol   = outCfg_q[`COC_OC_CH_POL];
	assign cmpPol  = outCfg_q[`COC_OC_CMP_POL];
	assign chIdle  = outCfg_q[`COC_OC_CH_IDLE];
	assign cmpIdle = outCfg_q[`COC_OC_CMP_IDLE];
	assign idleOffActive = !mainOutputEnable_q && idleOffSel && (chEn || cmpEn);
	assign deadHold = (deadCnt_q != 8'h00) ||
		(deadTime != 8'h00 && referenceWaveform != refDelay_q);

	// Dead-time counter restarts on every running reference edge and on entering idle.
	// Both outputs stay inactive until it expires, so the pair never overlaps.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			refDelay_q <= 1'b0;
			deadCnt_q <= 8'h00;
			idleLoaded_q <= 1'b0;
			idleSettled_q <= 1'b0;
		end else begin
			refDelay_q <= referenceWaveform;
			idleLoaded_q <= idleOffActive;
			idleSettled_q <= idleOffActive && idleLoaded_q && deadCnt_q == 8'h00;
			if ((mainOutputEnable_q && referenceWaveform != refDelay_q) ||
					(idleOffActive && !idleLoaded_q))
				deadCnt_q <= deadTime;
			else if (deadCnt_q != 8'h00)
				deadCnt_q <= deadCnt_q - 8'h01;
		end
	end

	// Output gating table.
	always @* begin
		chOutD = 1'b0;
		chEnD = 1'b0;
		cmpOutD = 1'b0;
		cmpEnD = 1'b0;
		if (mainOutputEnable_q) begin
			if (chEn && cmpEn) begin
				chEnD = 1'b1;
				cmpEnD = 1'b1;
				chOutD = (referenceWaveform && !deadHold) ^ chPol;
				cmpOutD = (!referenceWaveform && !deadHold) ^ cmpPol;
			end else if (!runOffSel) begin
				if (chEn) begin
					chOutD = referenceWaveform ^ chPol;
					chEnD = 1'b1;
				end
				if (cmpEn) begin
					cmpOutD = referenceWaveform ^ cmpPol;
					cmpEnD = 1'b1;
				end
				// Neither enabled leaves all four low.
			end else begin
				chOutD = chEn ? referenceWaveform ^ chPol : chPol;
				cmpOutD = cmpEn ? referenceWaveform ^ cmpPol : cmpPol;
				chEnD = chEn || cmpEn;
				cmpEnD = chEn || cmpEn;
			end
		end else if (idleOffSel && (chEn || cmpEn)) begin
			chEnD = 1'b1;
			cmpEnD = 1'b1;
			chOutD = chPol;
			cmpOutD = cmpPol;
			// Idle levels that would make both outputs active are refused.
			if (idleSettled_q && !((chIdle ^ chPol) && (cmpIdle ^ cmpPol))) begin
				chOutD = chIdle;
				cmpOutD = cmpIdle;
			end
		end
		// Otherwise both outputs stay disconnected.
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			channelOutput <= 1'b0;
			channelDriveEnable <= 1'b0;
			complementaryOutput <= 1'b0;
			complementaryDriveEnable <= 1'b0;
		end else begin
			channelOutput <= chOutD;
			channelDriveEnable <= chEnD;
			complementaryOutput <= cmpOutD;
			complementaryDriveEnable <= cmpEnD;
		end
	end
endmodule // coc_count_core
`default_nettype wire

// [coc_count_core_chk.sv]
// Bus handshake checker bound to the complementary output count core.
`timescale 1ns/1ns
`default_nettype none
`include "coc_consts.vh"
module coc_count_core_chk (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [7:0]  araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic        updateEvent
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered next cycle");
	a_read_refused: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	a_write_refused: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
		else $error("write not answered next cycle");
	a_bvalid_clears: assert property (bvalid && bready |=> !bvalid)
		else $error("write response repeated");
	a_hole_read: assert property (arvalid && arready && araddr == 8'h10
		|=> rresp == `COC_RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	a_reload_read: assert property (arvalid && arready && araddr == `COC_OFF_RELOAD
		|=> rresp == `COC_RESP_OKAY)
		else $error("reload read refused");
	c_update: cover property (updateEvent);
	c_slverr: cover property (bvalid && bresp == `COC_RESP_SLVERR);
	c_read: cover property (rvalid && rready);
endmodule // coc_count_core_chk
bind coc_count_core coc_count_core_chk u_chk (.clk(clk), .reset(reset), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rresp(rresp), .rvalid(rvalid), .rready(rready), .updateEvent(updateEvent));
`default_nettype wire

// [coc_count_core_test.sv]
// Self-checking bench for the complementary output count core.
`timescale 1ns/1ns
`default_nettype none
`include "coc_consts.vh"
module coc_count_core_test;
	logic        clk = 0, reset = 1, breakIn = 0, referenceWaveform = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, updateEvent;
	logic        channelOutput, channelDriveEnable, complementaryOutput;
	logic        complementaryDriveEnable;
	logic [1:0]  bresp, rresp, rs, ws;
	int          err_count = 0, n_checks = 0, cyc = 0, i, g;
	wire  [3:0]  outs = {channelOutput, channelDriveEnable, complementaryOutput,
		complementaryDriveEnable};
	// Row: ctrl byte, output config, reference, expected outputs, compare mask.
	// Rows with no channel enabled keep polarity and idle bits clear.
	logic [27:0] rows [9] = '{28'h010010F, 28'h010514F, 28'h050B1FF, 28'h010B05F,
		28'h050010F, 28'h05060DF, 28'h050907F, 28'h0003105, 28'h02131DF};
	coc_count_core dut (.clk, .reset, .breakIn, .referenceWaveform, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .channelOutput,
		.channelDriveEnable, .complementaryOutput, .complementaryDriveEnable, .updateEvent);
	always #25 clk = ~clk;
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Flags are read at the falling edge so the decision never races the rising edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		tb = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!tb) begin
			@(negedge clk);
			ta = awready & awvalid;
			tw = wready & wvalid;
			tb = bvalid;
			ws = bresp;
			@(posedge clk);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
		end
		bready <= 0;
	endtask
	task automatic rdr(input logic [7:0] a);
		logic ta, tb;
		tb = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (!tb) begin
			@(negedge clk);
			ta = arready & arvalid;
			tb = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge clk);
			if (ta) arvalid <= 0;
		end
		rready <= 0;
	endtask
	task automatic waitUpd(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!updateEvent && n < 200);
	endtask
	task automatic complete_run;
		if (err_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			complete_run;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		reset <= 0;
		rdr(`COC_OFF_CNT);
		chk("cnt", rd, 0);
		rdr(`COC_OFF_DIV);
		chk("div", rd, 0);
		rdr(`COC_OFF_RELOAD);
		chk("reload", rd, 32'h0000FFFF);
		for (i = 0; i < 9; i++) begin
			wr(`COC_OFF_OUTCFG, {24'h0, rows[i][19:12]});
			wr(`COC_OFF_CTRL, {24'h0, rows[i][27:20]});
			referenceWaveform <= rows[i][8];
			repeat (4) @(negedge clk);
			chk("gate", outs & rows[i][3:0], rows[i][7:4] & rows[i][3:0]);
		end
		// A long dead-time shows the polarity levels before the idle levels.
		wr(`COC_OFF_CTRL, 32'h0);
		wr(`COC_OFF_CTRL, 32'h00001402);
		@(negedge clk);
		chk("idlePol", outs, 4'h5);
		repeat (30) @(negedge clk);
		chk("idleLvl", outs, 4'hD);
		wr(`COC_OFF_OUTCFG, 32'h1);
		wr(`COC_OFF_CTRL, 32'h1);
		breakIn <= 1;
		repeat (3) @(negedge clk);
		chk("brkEn", {channelDriveEnable, complementaryDriveEnable}, 0);
		rdr(`COC_OFF_CTRL);
		chk("brkMoe", rd[0], 0);
		breakIn <= 0;
		wr(`COC_OFF_RELOAD, 32'h5);
		wr(`COC_OFF_DIV, 32'h0);
		wr(`COC_OFF_CNT, 32'h3);
		wr(`COC_OFF_EVENT, 32'h1);
		rdr(`COC_OFF_CNT);
		chk("ugCnt", rd, 0);
		wr(`COC_OFF_CTRL, 32'h8);
		waitUpd(g);
		waitUpd(g);
		chk("period", g, 6);
		wr(`COC_OFF_DIV, 32'h3);
		waitUpd(g);
		chk("oldDiv", g <= 6, 1);
		waitUpd(g);
		chk("newDiv", g, 24);
		wr(`COC_OFF_CTRL, 32'h18);
		rdr(`COC_OFF_CNT);
		g = rd;
		repeat (40) @(posedge clk);
		rdr(`COC_OFF_CNT);
		chk("slvRst", rd, g);
		wr(`COC_OFF_CTRL, 32'h0);
		wr(`COC_OFF_CNT, 32'h1234);
		rdr(`COC_OFF_CNT);
		chk("cntWr", rd, 32'h1234);
		wr(`COC_OFF_RELOAD, 32'h0);
		wr(`COC_OFF_CNT, 32'h7);
		wr(`COC_OFF_CTRL, 32'h8);
		repeat (30) @(posedge clk);
		rdr(`COC_OFF_CNT);
		chk("stall", rd, 32'h7);
		rdr(8'h10);
		chk("holeRd", {rs, rd[1:0]}, {`COC_RESP_SLVERR, 2'h0});
		wr(8'h10, 32'h1);
		chk("holeWr", ws, `COC_RESP_SLVERR);
		// A reset in mid-run must drop driven outputs and restore the reload value.
		wr(`COC_OFF_CTRL, 32'h1);
		reset <= 1;
		@(negedge clk);
		chk("rstOut", outs, 0);
		@(posedge clk);
		reset <= 0;
		rdr(`COC_OFF_RELOAD);
		chk("rstReload", rd, 32'h0000FFFF);
		complete_run;
	end
endmodule // coc_count_core_test
`default_nettype wire
